// ==== core/bbwc_core.sv ====
// Burst sequencing and per-lane write masking of a four-word burst memory
`timescale 1ns/1ns
`default_nettype none
`include "bbwc_defs.svh"

module bbwc_core #(
  parameter int DATA_W = `BBWC_DATA_W_WIDE,
  parameter int ADDR_W = `BBWC_ADDR_W_DEF,
  parameter int LANES = DATA_W / `BBWC_LANE_W
) (
  input wire logic clock,
  input wire logic resetn,
  input wire bbwc_pkg::bbwc_req_t req_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] d_k,
  input wire logic [DATA_W-1:0] d_kn,
  input wire logic [LANES-1:0] byte_lane_mask_k_n,
  input wire logic [LANES-1:0] byte_lane_mask_kn_n,
  input wire logic q_ready,
  output logic q_valid,
  output logic [DATA_W-1:0] q_k,
  output logic [DATA_W-1:0] q_kn
);

  localparam int IDX_W = ADDR_W + `BBWC_OFS_W;

  generate
    if ((DATA_W != `BBWC_DATA_W_WIDE && DATA_W != `BBWC_DATA_W_NARROW) ||
        LANES * `BBWC_LANE_W != DATA_W || ADDR_W < 1) begin : g_bad_cfg
      $error("bbwc_core needs an 18 or 36 bit word in 9-bit lanes");
    end
  endgenerate

  logic [DATA_W-1:0] mem [0:(1 << IDX_W)-1];

  function automatic logic [IDX_W-1:0] word_idx(input logic [ADDR_W-1:0] a, input logic [`BBWC_OFS_W-1:0] ofs);
    word_idx = {a, ofs};
  endfunction

  // ---------------- Write machine ----------------
  bbwc_pkg::bbwc_wr_state_t wr_state_q, wr_state_d;
  logic [ADDR_W-1:0] wr_addr_q;

  // Read wins a tie; a write is not taken on the edge right after one was
  wire wr_accept = !req_n.wr_n && req_n.rd_n && wr_state_q != bbwc_pkg::BBWC_W_BEAT01;
  wire wr_beat01 = wr_state_q == bbwc_pkg::BBWC_W_BEAT01;
  wire wr_beat23 = wr_state_q == bbwc_pkg::BBWC_W_BEAT23;
  wire wr_active = wr_beat01 || wr_beat23;
  wire [IDX_W-1:0] wr_idx_k = word_idx(wr_addr_q, wr_beat23 ? `BBWC_OFS_2 : `BBWC_OFS_0);
  wire [IDX_W-1:0] wr_idx_kn = word_idx(wr_addr_q, wr_beat23 ? `BBWC_OFS_3 : `BBWC_OFS_1);

  logic [DATA_W-1:0] wen_k;
  logic [DATA_W-1:0] wen_kn;
  genvar gl;
  generate
    for (gl = 0; gl < LANES; gl++) begin : g_lane
      // Each beat expands its own mask, so patterns may differ beat to beat
      assign wen_k[gl*`BBWC_LANE_W +: `BBWC_LANE_W] = {`BBWC_LANE_W{!byte_lane_mask_k_n[gl]}};
      assign wen_kn[gl*`BBWC_LANE_W +: `BBWC_LANE_W] = {`BBWC_LANE_W{!byte_lane_mask_kn_n[gl]}};
    end
  endgenerate

  wire [DATA_W-1:0] wr_new_k = (mem[wr_idx_k] & ~wen_k) | (d_k & wen_k);
  wire [DATA_W-1:0] wr_new_kn = (mem[wr_idx_kn] & ~wen_kn) | (d_kn & wen_kn);

  always_comb begin
    case (wr_state_q)
      bbwc_pkg::BBWC_W_IDLE: wr_state_d = wr_accept ? bbwc_pkg::BBWC_W_BEAT01 : bbwc_pkg::BBWC_W_IDLE;
      bbwc_pkg::BBWC_W_BEAT01: wr_state_d = bbwc_pkg::BBWC_W_BEAT23;
      bbwc_pkg::BBWC_W_BEAT23: wr_state_d = wr_accept ? bbwc_pkg::BBWC_W_BEAT01 : bbwc_pkg::BBWC_W_IDLE;
      default: wr_state_d = bbwc_pkg::BBWC_W_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      wr_state_q <= bbwc_pkg::BBWC_W_IDLE;
    end else begin
      wr_state_q <= wr_state_d;
    end
  end

  // Words 0,1 are taken at edge t+1 and words 2,3 at t+2
  always_ff @(posedge clock) begin
    if (wr_accept) begin
      wr_addr_q <= addr;
    end
    if (wr_active) begin
      mem[wr_idx_k] <= wr_new_k;
      mem[wr_idx_kn] <= wr_new_kn;
    end
  end

  // ---------------- Read machine ----------------
  logic rd_s1_q, rd_s2_q, rd_s3_q;
  logic [ADDR_W-1:0] rd_a1_q, rd_a2_q, rd_a3_q;
  logic buf_in_ready;

  wire rd_push = rd_s2_q || rd_s3_q;
  // A full buffer freezes the read pipe; latency stretches but no word is lost
  wire rd_stall = rd_push && !buf_in_ready;
  wire rd_accept = !req_n.rd_n && !rd_s1_q && !rd_stall;
  wire [IDX_W-1:0] rd_idx_k = rd_s2_q ? word_idx(rd_a2_q, `BBWC_OFS_0) : word_idx(rd_a3_q, `BBWC_OFS_2);
  wire [IDX_W-1:0] rd_idx_kn = rd_s2_q ? word_idx(rd_a2_q, `BBWC_OFS_1) : word_idx(rd_a3_q, `BBWC_OFS_3);
  wire [2*DATA_W-1:0] rd_pair = {mem[rd_idx_kn], mem[rd_idx_k]};

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rd_s1_q <= 1'b0;
      rd_s2_q <= 1'b0;
      rd_s3_q <= 1'b0;
    end else if (!rd_stall) begin
      rd_s1_q <= rd_accept;
      rd_s2_q <= rd_s1_q;
      rd_s3_q <= rd_s2_q;
    end
  end

  always_ff @(posedge clock) begin
    if (!rd_stall) begin
      rd_a1_q <= addr;
      rd_a2_q <= rd_a1_q;
      rd_a3_q <= rd_a2_q;
    end
  end

  logic [2*DATA_W-1:0] buf_out;

  // Words 0,1 land on the outputs at edge t+2 and words 2,3 at t+3
  bbwc_skid #(
    .WIDTH(2 * DATA_W),
    .DEPTH(`BBWC_BUF_DEPTH)
  ) u_skid (
    .clock(clock),
    .resetn(resetn),
    .in_valid(rd_push),
    .in_ready(buf_in_ready),
    .in_data(rd_pair),
    .out_valid(q_valid),
    .out_ready(q_ready),
    .out_data(buf_out)
  );

  assign q_k = buf_out[DATA_W-1:0];
  assign q_kn = buf_out[2*DATA_W-1:DATA_W];

  // ---------------- Checks ----------------
  wire [`BBWC_LANE_W-1:0] chk_lane0_k = mem[wr_idx_k][`BBWC_LANE_W-1:0];

  AST_WR_SEQ: assert property (@(posedge clock) disable iff (!resetn)
    wr_accept |=> wr_beat01 ##1 wr_beat23)
    else $error("write burst did not run two beat cycles");

  AST_RD_TIE: assert property (@(posedge clock) disable iff (!resetn)
    (!req_n.rd_n && !req_n.wr_n) |=> !wr_beat01)
    else $error("write started together with a read");

  AST_WR_B2B: assert property (@(posedge clock) disable iff (!resetn)
    wr_accept |=> !wr_accept)
    else $error("second consecutive write was taken");

  AST_RD_B2B: assert property (@(posedge clock) disable iff (!resetn)
    rd_accept |=> !rd_accept)
    else $error("second consecutive read was taken");

  AST_NOP: assert property (@(posedge clock) disable iff (!resetn)
    (req_n.rd_n && req_n.wr_n && !rd_stall) |=> (!rd_s1_q && !wr_beat01))
    else $error("idle cycle started a burst");

  AST_RD_PIPE: assert property (@(posedge clock) disable iff (!resetn)
    (rd_accept ##1 !rd_stall) |=> rd_s2_q && buf_in_ready ##1 rd_s3_q)
    else $error("read words not pushed in the two cycles after the wait cycle");

  AST_LANE_KEEP: assert property (@(posedge clock) disable iff (!resetn)
    (wr_active && byte_lane_mask_k_n[0]) |=>
      mem[$past(wr_idx_k)][`BBWC_LANE_W-1:0] == $past(chk_lane0_k))
    else $error("masked lane was overwritten");

  AST_LANE_WRITE: assert property (@(posedge clock) disable iff (!resetn)
    (wr_active && !byte_lane_mask_kn_n[0] && wr_idx_kn != wr_idx_k) |=>
      mem[$past(wr_idx_kn)][`BBWC_LANE_W-1:0] == $past(d_kn[`BBWC_LANE_W-1:0]))
    else $error("enabled lane did not take its beat data");

  AST_RD_RUN: assert property (@(posedge clock) disable iff (!resetn)
    (wr_beat01 && rd_s1_q && !rd_stall) |=> (wr_beat23 && rd_s2_q))
    else $error("read and write bursts did not advance together");

endmodule
`default_nettype wire

// ==== core/bbwc_defs.svh ====
// Constants for the burst byte-write control block
`ifndef BBWC_DEFS_SVH
`define BBWC_DEFS_SVH

`define BBWC_LANE_W 9
`define BBWC_OFS_W 2
`define BBWC_OFS_0 2'h0
`define BBWC_OFS_1 2'h1
`define BBWC_OFS_2 2'h2
`define BBWC_OFS_3 2'h3
`define BBWC_BURST_LEN 4
`define BBWC_DATA_W_WIDE 36
`define BBWC_DATA_W_NARROW 18
`define BBWC_ADDR_W_DEF 8
`define BBWC_BUF_DEPTH 2

`endif

// ==== core/bbwc_pkg.sv ====
// Types shared by the burst byte-write control block
package bbwc_pkg;

  // Active-low request pair sampled on the true strobe edge
  typedef struct packed {
    logic rd_n;
    logic wr_n;
  } bbwc_req_t;

  typedef enum logic [1:0] {
    BBWC_W_IDLE,
    BBWC_W_BEAT01,
    BBWC_W_BEAT23
  } bbwc_wr_state_t;

endpackage

// ==== core/bbwc_skid.sv ====
// Two-entry valid/ready buffer with registered outputs
`timescale 1ns/1ns
`default_nettype none
`include "bbwc_defs.svh"

module bbwc_skid #(
  parameter int WIDTH = 2 * `BBWC_DATA_W_WIDE,
  parameter int DEPTH = `BBWC_BUF_DEPTH
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  generate
    if (DEPTH != `BBWC_BUF_DEPTH) begin : g_bad_depth
      $error("bbwc_skid supports only a depth of two");
    end
  endgenerate

  logic out_valid_q;
  logic skid_valid_q;
  logic [WIDTH-1:0] out_data_q;
  logic [WIDTH-1:0] skid_data_q;
  wire out_free = !out_valid_q || out_ready;

  // Ready comes from a flop so the producer never sees a combinational path from out_ready
  assign in_ready = !skid_valid_q;
  assign out_valid = out_valid_q;
  assign out_data = out_data_q;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      out_valid_q <= 1'b0;
      skid_valid_q <= 1'b0;
    end else if (out_free) begin
      out_valid_q <= skid_valid_q || in_valid;
      skid_valid_q <= 1'b0;
    end else if (in_valid && !skid_valid_q) begin
      skid_valid_q <= 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (out_free) begin
      out_data_q <= skid_valid_q ? skid_data_q : in_data;
    end else if (in_valid && !skid_valid_q) begin
      skid_data_q <= in_data;
    end
  end

endmodule
`default_nettype wire

// ==== dv/bbwc_ctl_model.sv ====
// Memory controller model driving requests and write beats
`timescale 1ns/1ns
`default_nettype none
module bbwc_ctl_model (
  input wire logic clock,
  output var bbwc_pkg::bbwc_req_t req_n = 2'h3,
  output logic [7:0] addr = 8'h00,
  output logic [35:0] d_k = 36'h0,
  output logic [35:0] d_kn = 36'h0,
  output logic [3:0] mk_n = 4'hF,
  output logic [3:0] mkn_n = 4'hF
);
  // One strobe cycle: all lines change together just after the true edge
  task automatic cyc(input logic [1:0] r, input logic [7:0] a, input logic [35:0] x, y, input logic [3:0] m, n);
    @(posedge clock);
    req_n <= r;
    addr <= a;
    d_k <= x;
    d_kn <= y;
    mk_n <= m;
    mkn_n <= n;
  endtask
  // Released lines flip so stale data never passes for a beat
  task automatic idle();
    cyc(2'h3, ~addr, ~d_k, ~d_kn, 4'hF, 4'hF);
  endtask
endmodule
`default_nettype wire

// ==== dv/bbwc_core_tb.sv ====
// Self-checking bench for the burst byte-write control block
`timescale 1ns/1ns
`default_nettype none
module bbwc_core_tb;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic q_ready = 1'b1;
  logic q_valid;
  bbwc_pkg::bbwc_req_t req_n;
  logic [7:0] addr;
  logic [35:0] d_k, d_kn, q_k, q_kn;
  logic [3:0] mk_n, mkn_n;
  logic [35:0] mem [logic [9:0]];
  int num_errors = 0;
  int n_compared = 0;
  always #25 clock = ~clock;
  bbwc_ctl_model u_ctl (.clock(clock), .req_n(req_n), .addr(addr), .d_k(d_k), .d_kn(d_kn), .mk_n(mk_n),
    .mkn_n(mkn_n));
  bbwc_core dut_u (.clock(clock), .resetn(resetn), .req_n(req_n), .addr(addr), .d_k(d_k), .d_kn(d_kn),
    .byte_lane_mask_k_n(mk_n), .byte_lane_mask_kn_n(mkn_n), .q_ready(q_ready), .q_valid(q_valid),
    .q_k(q_k), .q_kn(q_kn));
  task automatic cmp(input logic [35:0] got, input logic [35:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %0t got %h exp %h", $time, got, exp);
    end
  endtask
  function automatic logic [143:0] pat(input logic [7:0] s);
    for (int i = 0; i < 16; i++) begin
      pat[9*i +: 9] = {s[0] ^ i[0], s + 8'(i)};
    end
  endfunction
  // Beat masks sit lowest beat first in m
  task automatic wr(input logic [7:0] a, input logic [143:0] d, input logic [15:0] m);
    u_ctl.cyc(2'h2, a, ~d_k, ~d_kn, 4'hF, 4'hF);
    u_ctl.cyc(2'h3, ~a, d[35:0], d[71:36], m[3:0], m[7:4]);
    u_ctl.cyc(2'h3, ~a, d[107:72], d[143:108], m[11:8], m[15:12]);
    u_ctl.idle();
    for (int i = 0; i < 16; i++) begin
      if (!m[i]) begin
        mem[{a, 2'(i / 4)}][9*(i%4) +: 9] = d[9*i +: 9];
      end
    end
  endtask
  task automatic chk(input logic [7:0] a);
    @(negedge clock);
    cmp(36'(q_valid), 36'h0);
    @(negedge clock);
    cmp(36'(q_valid), 36'h1);
    cmp(q_k, mem[{a, 2'h0}]);
    cmp(q_kn, mem[{a, 2'h1}]);
    @(negedge clock);
    cmp(q_k, mem[{a, 2'h2}]);
    cmp(q_kn, mem[{a, 2'h3}]);
    @(negedge clock);
    cmp(36'(q_valid), 36'h0);
  endtask
  task automatic rd(input logic [7:0] a);
    u_ctl.cyc(2'h1, a, ~d_k, ~d_kn, 4'hF, 4'hF);
    u_ctl.idle();
    @(posedge clock);
    chk(a);
  endtask
  task automatic t_mask();
    wr(8'h05, pat(8'h11), 16'h0);
    rd(8'h05);
    wr(8'h05, pat(8'h62), 16'h7BDE);
    rd(8'h05);
    wr(8'h05, pat(8'h93), 16'hF0A5);
    rd(8'h05);
  endtask
  // Read and an illegal write share one edge while an earlier write is mid-burst
  task automatic t_overlap();
    logic [143:0] p;
    p = pat(8'h47);
    wr(8'h40, pat(8'h2C), 16'h0);
    u_ctl.cyc(2'h2, 8'h30, ~d_k, ~d_kn, 4'hF, 4'hF);
    u_ctl.cyc(2'h0, 8'h40, p[35:0], p[71:36], 4'h0, 4'h0);
    u_ctl.cyc(2'h3, 8'hCF, p[107:72], p[143:108], 4'h0, 4'h0);
    u_ctl.idle();
    for (int i = 0; i < 4; i++) begin
      mem[{8'h30, 2'(i)}] = p[36*i +: 36];
    end
    chk(8'h40);
    rd(8'h30);
    // Second read on the very next edge must be dropped: q_valid falls after two pairs
    u_ctl.cyc(2'h1, 8'h40, ~d_k, ~d_kn, 4'hF, 4'hF);
    u_ctl.cyc(2'h1, 8'h40, ~d_k, ~d_kn, 4'hF, 4'hF);
    u_ctl.idle();
    chk(8'h40);
  endtask
  // A stalled receiver must lose no word of a buffered burst
  task automatic t_stall();
    int k;
    k = 0;
    @(posedge clock);
    q_ready <= 1'b0;
    u_ctl.cyc(2'h1, 8'h05, ~d_k, ~d_kn, 4'hF, 4'hF);
    u_ctl.idle();
    repeat (8) @(posedge clock);
    q_ready <= 1'b1;
    for (int i = 0; i < 20 && k < 2; i++) begin
      @(negedge clock);
      if (q_valid === 1'b1) begin
        cmp(q_k, mem[{8'h05, 2'(2 * k)}]);
        cmp(q_kn, mem[{8'h05, 2'(2 * k + 1)}]);
        k++;
      end
    end
    cmp(36'(k), 36'h2);
    if (k != 2) begin
      finish_test();
    end
  endtask
  task automatic finish_test();
    if (num_errors == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clock);
    resetn <= 1'b1;
    t_mask();
    t_overlap();
    t_stall();
    finish_test();
  end
endmodule
`default_nettype wire
